/* lsc_pkg.sv */
// constants shared by the line supervision control block
package lsc_pkg;

    // register offsets, as seen on the plain register port
    localparam logic [7:0] LINEFEED_ADDR     = 8'h40;
    localparam logic [7:0] AUTO_MAN_ADDR     = 8'h43;
    localparam logic [7:0] DET_STATUS_ADDR   = 8'h44;
    localparam logic [7:0] LC_DEBOUNCE_ADDR  = 8'h45;
    localparam logic [7:0] RT_DEBOUNCE_ADDR  = 8'h46;
    localparam logic [7:0] LOOP_CUR_ADDR     = 8'h47;
    localparam logic [7:0] ONHOOK_VOLT_ADDR  = 8'h48;
    localparam logic [7:0] COMMON_VOLT_ADDR  = 8'h49;
    localparam logic [7:0] IRQ_STATUS_ADDR   = 8'h50;
    localparam logic [7:0] IRQ_MASK_ADDR     = 8'h51;

    // field positions of the automatic/manual control register
    localparam int CM_MANUAL_BIT   = 6;
    localparam int DIF_MANUAL_BIT  = 5;
    localparam int SPEEDUP_BIT     = 4;
    localparam int AUTO_RT_BIT     = 2;
    localparam int AUTO_LC_BIT     = 1;
    localparam int AUTO_PA_BIT     = 0;

    // field positions of the detect status register
    localparam int RAW_DET_BIT     = 2;
    localparam int RT_FLAG_BIT     = 1;
    localparam int LC_FLAG_BIT     = 0;

    // event bits of the interrupt status and mask registers
    localparam int EV_RT_BIT       = 2;
    localparam int EV_LC_BIT       = 1;
    localparam int EV_PA_BIT       = 0;

    // linefeed register layout: actual state high, requested state low
    localparam int ACT_STATE_LSB   = 4;

    // values after reset
    localparam logic [7:0] AUTO_MAN_RST    = 8'h00;
    localparam logic [6:0] LC_DEBOUNCE_RST = 7'h0A;
    localparam logic [6:0] RT_DEBOUNCE_RST = 7'h0A;
    localparam logic [2:0] LOOP_CUR_RST    = 3'h0;
    localparam logic [5:0] ONHOOK_VOLT_RST = 6'h20;
    localparam logic [5:0] COMMON_VOLT_RST = 6'h02;
    localparam logic [2:0] IRQ_MASK_RST    = 3'h0;

    // debounce step of 1.25 ms at a 20 ns clock
    localparam int CLK_PERIOD_NS   = 20;
    localparam int DEB_STEP_NS     = 1250000;
    localparam int DEB_TICK_CYCLES = DEB_STEP_NS / CLK_PERIOD_NS;

    // loop current: base and step in mA
    localparam logic [5:0] CUR_BASE_MA  = 6'h14;
    localparam logic [5:0] CUR_STEP_MA  = 6'h03;

    // linefeed state codes
    typedef enum logic [2:0] {
        LSC_OPEN         = 3'h0,
        LSC_FWD_ACTIVE   = 3'h1,
        LSC_FWD_ONHOOK   = 3'h2,
        LSC_TIP_OPEN     = 3'h3,
        LSC_RINGING      = 3'h4,
        LSC_REV_ACTIVE   = 3'h5,
        LSC_REV_ONHOOK   = 3'h6,
        LSC_RING_OPEN    = 3'h7
    } lsc_line_state_type;

endpackage

/* lsc_deb_if.sv */
// interface between the supervision top and one detector debounce filter
`timescale 1ns/1ps
interface lsc_deb_if;
    logic       tick;
    logic [6:0] interval;
    logic       raw;
    logic       filt;

    modport ctrl   (output tick, output interval, output raw, input filt);
    modport filter (input tick, input interval, input raw, output filt);
endinterface

/* lsc_debounce.sv */
// steady-state debounce filter for one detector output
`timescale 1ns/1ps
module lsc_debounce (
    input wire logic clk,
    input wire logic rst,
    lsc_deb_if.filter deb
);

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic       prev_q;
    logic       filt_q;
    logic       filt_d;

    // count whole steps of steady input; restart on any change
    always_comb begin
        cnt_d  = cnt_q;
        filt_d = filt_q;
        if (deb.raw != prev_q) begin
            cnt_d = 7'h00;
        end else begin
            if (deb.tick && cnt_q != 7'h7F) begin
                cnt_d = cnt_q + 7'h01; // saturate so long intervals still settle
            end
            if (deb.raw != filt_q && cnt_q >= deb.interval) begin
                filt_d = deb.raw;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q  <= 7'h00;
            prev_q <= 1'b0;
            filt_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            prev_q <= deb.raw;
            filt_q <= filt_d;
        end
    end

    assign deb.filt = filt_q;

endmodule

/* lsc_line_supervision.sv */
// line supervision control: auto/manual control, detect debounce and status
`timescale 1ns/1ps
module lsc_line_supervision #(
    parameter int TICK_CYCLES = lsc_pkg::DEB_TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       ring_trip_det,
    input  wire logic       loop_close_det,
    input  wire logic       power_alarm,
    output logic      [2:0] actual_line_state,
    output logic            tip_force_en,
    output logic            ring_force_en,
    output logic      [5:0] common_mode_voltage_setting,
    output logic            diff_force_en,
    output logic      [5:0] onhook_voltage_setting,
    output logic            speedup_en,
    output logic      [2:0] loop_current_setting,
    output logic      [5:0] loop_current_ma,
    output logic            irq
);

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    // two-flop synchronisers for the detector and alarm pins
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {ring_trip_det, loop_close_det, power_alarm};
            sync2_q <= sync1_q;
        end
    end

    logic rt_raw;
    logic lc_raw;
    logic pa_raw;
    assign rt_raw = sync2_q[2];
    assign lc_raw = sync2_q[1];
    assign pa_raw = sync2_q[0];

    // 1.25 ms step enable shared by both debounce filters
    logic [TICK_W-1:0] div_q;
    logic [TICK_W-1:0] div_d;
    logic              tick_q;
    logic              tick_d;

    always_comb begin
        tick_d = 1'b0;
        div_d  = div_q + TICK_W'(1);
        if (div_q == TICK_W'(TICK_CYCLES - 1)) begin
            div_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    // software-written configuration
    logic [7:0] auto_man_q;
    logic [7:0] auto_man_d;
    logic [6:0] lc_deb_q;
    logic [6:0] lc_deb_d;
    logic [6:0] rt_deb_q;
    logic [6:0] rt_deb_d;
    logic [2:0] cur_lim_q;
    logic [2:0] cur_lim_d;
    logic [5:0] onhook_v_q;
    logic [5:0] onhook_v_d;
    logic [5:0] cm_v_q;
    logic [5:0] cm_v_d;
    logic [2:0] req_state_q;
    logic [2:0] req_state_d;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_mask_d;

    // debounce filters for ring trip and loop closure
    lsc_deb_if rt_if ();
    lsc_deb_if lc_if ();

    assign rt_if.tick     = tick_q;
    assign rt_if.interval = rt_deb_q;
    assign rt_if.raw      = rt_raw;
    assign lc_if.tick     = tick_q;
    assign lc_if.interval = lc_deb_q;
    assign lc_if.raw      = lc_raw;

    lsc_debounce u_rt_deb (
        .clk (clk),
        .rst (rst),
        .deb (rt_if.filter)
    );

    lsc_debounce u_lc_deb (
        .clk (clk),
        .rst (rst),
        .deb (lc_if.filter)
    );

    logic rt_flag;
    logic lc_flag;
    assign rt_flag = rt_if.filt;
    assign lc_flag = lc_if.filt;

    // edge detection of filtered flags and synchronised alarm
    logic rt_prev_q;
    logic lc_prev_q;
    logic pa_prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            rt_prev_q <= 1'b0;
            lc_prev_q <= 1'b0;
            pa_prev_q <= 1'b0;
        end else begin
            rt_prev_q <= rt_flag;
            lc_prev_q <= lc_flag;
            pa_prev_q <= pa_raw;
        end
    end

    logic rt_rise;
    logic lc_rise;
    logic pa_rise;
    assign rt_rise = rt_flag & ~rt_prev_q;
    assign lc_rise = lc_flag & ~lc_prev_q;
    assign pa_rise = pa_raw & ~pa_prev_q;

    // register write decode and actual line state
    logic wr_feed;
    assign wr_feed = wr && addr == lsc_pkg::LINEFEED_ADDR;

    logic [2:0] act_state_q;
    logic [2:0] act_state_d;

    always_comb begin
        auto_man_d  = auto_man_q;
        lc_deb_d    = lc_deb_q;
        rt_deb_d    = rt_deb_q;
        cur_lim_d   = cur_lim_q;
        onhook_v_d  = onhook_v_q;
        cm_v_d      = cm_v_q;
        req_state_d = req_state_q;
        irq_mask_d  = irq_mask_q;
        if (wr) begin
            if (addr == lsc_pkg::LINEFEED_ADDR) begin
                req_state_d = wdata[2:0];
            end else if (addr == lsc_pkg::AUTO_MAN_ADDR) begin
                auto_man_d = wdata & 8'h77; // bits 7 and 3 stay zero
            end else if (addr == lsc_pkg::LC_DEBOUNCE_ADDR) begin
                lc_deb_d = wdata[6:0];
            end else if (addr == lsc_pkg::RT_DEBOUNCE_ADDR) begin
                rt_deb_d = wdata[6:0];
            end else if (addr == lsc_pkg::LOOP_CUR_ADDR) begin
                cur_lim_d = wdata[2:0];
            end else if (addr == lsc_pkg::ONHOOK_VOLT_ADDR) begin
                onhook_v_d = wdata[5:0];
            end else if (addr == lsc_pkg::COMMON_VOLT_ADDR) begin
                cm_v_d = wdata[5:0];
            end else if (addr == lsc_pkg::IRQ_MASK_ADDR) begin
                irq_mask_d = wdata[2:0];
            end
        end
    end

    // automatic transitions override the requested state; power alarm wins
    always_comb begin
        act_state_d = act_state_q;
        if (wr_feed) begin
            act_state_d = wdata[2:0];
        end
        if (rt_rise && auto_man_q[lsc_pkg::AUTO_RT_BIT]) begin
            act_state_d = lsc_pkg::LSC_FWD_ACTIVE;
        end
        if (lc_rise && auto_man_q[lsc_pkg::AUTO_LC_BIT]) begin
            act_state_d = lsc_pkg::LSC_FWD_ACTIVE;
        end
        if (pa_rise && auto_man_q[lsc_pkg::AUTO_PA_BIT]) begin
            act_state_d = lsc_pkg::LSC_OPEN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            auto_man_q  <= lsc_pkg::AUTO_MAN_RST;
            lc_deb_q    <= lsc_pkg::LC_DEBOUNCE_RST;
            rt_deb_q    <= lsc_pkg::RT_DEBOUNCE_RST;
            cur_lim_q   <= lsc_pkg::LOOP_CUR_RST;
            onhook_v_q  <= lsc_pkg::ONHOOK_VOLT_RST;
            cm_v_q      <= lsc_pkg::COMMON_VOLT_RST;
            req_state_q <= lsc_pkg::LSC_OPEN;
            irq_mask_q  <= lsc_pkg::IRQ_MASK_RST;
            act_state_q <= lsc_pkg::LSC_OPEN;
        end else begin
            auto_man_q  <= auto_man_d;
            lc_deb_q    <= lc_deb_d;
            rt_deb_q    <= rt_deb_d;
            cur_lim_q   <= cur_lim_d;
            onhook_v_q  <= onhook_v_d;
            cm_v_q      <= cm_v_d;
            req_state_q <= req_state_d;
            irq_mask_q  <= irq_mask_d;
            act_state_q <= act_state_d;
        end
    end

    // sticky event bits, write one to clear; a new event beats the clear
    logic [2:0] irq_stat_q;
    logic [2:0] irq_stat_d;
    logic [2:0] events;
    assign events = {rt_rise, lc_rise, pa_rise};

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr && addr == lsc_pkg::IRQ_STATUS_ADDR) begin
            irq_stat_d = irq_stat_q & ~wdata[2:0];
        end
        irq_stat_d = irq_stat_d | events;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // status register: raw bit is active low, high when nothing detected
    logic [7:0] det_status;
    always_comb begin
        det_status = 8'h00;
        det_status[lsc_pkg::RAW_DET_BIT] = ~(rt_raw | lc_raw);
        det_status[lsc_pkg::RT_FLAG_BIT] = rt_flag;
        det_status[lsc_pkg::LC_FLAG_BIT] = lc_flag;
    end

    // read mux; unmapped addresses read zero
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (addr == lsc_pkg::LINEFEED_ADDR) begin
            rdata_d = {1'b0, act_state_q, 1'b0, req_state_q};
        end else if (addr == lsc_pkg::AUTO_MAN_ADDR) begin
            rdata_d = auto_man_q;
        end else if (addr == lsc_pkg::DET_STATUS_ADDR) begin
            rdata_d = det_status;
        end else if (addr == lsc_pkg::LC_DEBOUNCE_ADDR) begin
            rdata_d = {1'b0, lc_deb_q};
        end else if (addr == lsc_pkg::RT_DEBOUNCE_ADDR) begin
            rdata_d = {1'b0, rt_deb_q};
        end else if (addr == lsc_pkg::LOOP_CUR_ADDR) begin
            rdata_d = {5'h00, cur_lim_q};
        end else if (addr == lsc_pkg::ONHOOK_VOLT_ADDR) begin
            rdata_d = {2'h0, onhook_v_q};
        end else if (addr == lsc_pkg::COMMON_VOLT_ADDR) begin
            rdata_d = {2'h0, cm_v_q};
        end else if (addr == lsc_pkg::IRQ_STATUS_ADDR) begin
            rdata_d = {5'h00, irq_stat_q};
        end else if (addr == lsc_pkg::IRQ_MASK_ADDR) begin
            rdata_d = {5'h00, irq_mask_q};
        end
        if (!rd) begin
            rdata_d = 8'h00; // data only stands in the cycle after a read
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // feed control outputs; forward states drive TIP, reverse drive RING
    logic fwd_state;
    logic rev_state;
    assign fwd_state = act_state_q == lsc_pkg::LSC_FWD_ACTIVE
                    || act_state_q == lsc_pkg::LSC_FWD_ONHOOK;
    assign rev_state = act_state_q == lsc_pkg::LSC_REV_ACTIVE
                    || act_state_q == lsc_pkg::LSC_REV_ONHOOK;

    assign tip_force_en  = auto_man_q[lsc_pkg::CM_MANUAL_BIT] & fwd_state;
    assign ring_force_en = auto_man_q[lsc_pkg::CM_MANUAL_BIT] & rev_state;
    assign common_mode_voltage_setting = cm_v_q;
    assign diff_force_en = auto_man_q[lsc_pkg::DIF_MANUAL_BIT];
    assign onhook_voltage_setting = onhook_v_q;
    assign speedup_en = auto_man_q[lsc_pkg::SPEEDUP_BIT];
    assign loop_current_setting = cur_lim_q;
    // 20 mA plus 3 mA per code, at most 41 mA so six bits suffice
    assign loop_current_ma = lsc_pkg::CUR_BASE_MA
                           + 6'(cur_lim_q * lsc_pkg::CUR_STEP_MA);
    assign actual_line_state = act_state_q;
    assign rdata = rdata_q;
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule

/* lsc_loop_model.sv */
// behavioural subscriber loop: turns bench commands into detector pin levels
`timescale 1ns/1ps
module lsc_loop_model (
    input  wire logic clk,
    input  wire logic hook_cmd,
    input  wire logic trip_cmd,
    input  wire logic alarm_cmd,
    output logic      loop_close_det = 1'b0,
    output logic      ring_trip_det = 1'b0,
    output logic      power_alarm = 1'b0
);
    // detector comparators settle one clock after the line changes
    always @(posedge clk) begin
        loop_close_det <= hook_cmd;
        ring_trip_det  <= trip_cmd;
        power_alarm    <= alarm_cmd;
    end
endmodule

/* lsc_monitor.sv */
// concurrent checks on the line supervision control ports
`timescale 1ns/1ps
module lsc_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       ring_trip_det,
    input wire logic       loop_close_det,
    input wire logic       power_alarm,
    input wire logic [2:0] actual_line_state,
    input wire logic       tip_force_en,
    input wire logic       ring_force_en,
    input wire logic       diff_force_en,
    input wire logic [2:0] loop_current_setting,
    input wire logic [5:0] loop_current_ma
);
    logic [7:0] ctl_q;
    logic [1:0] lfw_q;
    logic [1:0] pin_q;
    logic [2:0] calm_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // control shadow and recent linefeed writes, rebuilt from the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= 8'h00;
            lfw_q <= 2'h0;
        end else begin
            if (wr && addr == lsc_pkg::AUTO_MAN_ADDR) ctl_q <= wdata;
            lfw_q <= {lfw_q[0], wr && addr == lsc_pkg::LINEFEED_ADDR};
        end
    end
    // calm pins only: a read racing the synchroniser would be ambiguous
    always_ff @(posedge clk) begin
        pin_q <= {ring_trip_det, loop_close_det};
        if (rst || pin_q != {ring_trip_det, loop_close_det}) calm_q <= 3'h0;
        else if (calm_q != 3'h7) calm_q <= calm_q + 3'h1;
    end
    a_tip_force: assert property (tip_force_en ==
        (ctl_q[6] && actual_line_state inside {3'h1, 3'h2})) else $error("tip force wrong");
    a_ring_force: assert property (ring_force_en ==
        (ctl_q[6] && actual_line_state inside {3'h5, 3'h6})) else $error("ring force wrong");
    a_diff_force: assert property (diff_force_en == ctl_q[5])
        else $error("differential force wrong");
    a_cur_ma: assert property (loop_current_ma == 6'h14 + 6'h03 * loop_current_setting)
        else $error("loop current mA wrong");
    a_cur_write: assert property (wr && addr == lsc_pkg::LOOP_CUR_ADDR |=>
        {5'h00, loop_current_setting} == ($past(wdata) & 8'h07)) else $error("limit not taken");
    a_alarm_open: assert property (ctl_q[0] && $rose(power_alarm) |->
        ##[1:6] actual_line_state == 3'h0) else $error("alarm did not open line");
    a_manual_hold: assert property (ctl_q[2:0] == 3'h0 && $past(ctl_q) == ctl_q
        && lfw_q == 2'h0 |-> $stable(actual_line_state)) else $error("state moved in manual");
    a_raw_status: assert property (rd && addr == lsc_pkg::DET_STATUS_ADDR && calm_q > 3'h3
        |=> rdata[2] == ~($past(ring_trip_det) | $past(loop_close_det)) && rdata[7:3] == 5'h00)
        else $error("raw detect bit wrong");
    c_lc_auto: cover property (ctl_q[1] && $rose(actual_line_state == 3'h1));
    c_alarm: cover property (ctl_q[0] && $rose(power_alarm));
    c_status_rd: cover property (rd && addr == lsc_pkg::DET_STATUS_ADDR);
endmodule
bind lsc_line_supervision lsc_monitor #(.TICK_CYCLES(TICK_CYCLES)) lsc_monitor_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ring_trip_det(ring_trip_det), .loop_close_det(loop_close_det),
    .power_alarm(power_alarm), .actual_line_state(actual_line_state),
    .tip_force_en(tip_force_en), .ring_force_en(ring_force_en),
    .diff_force_en(diff_force_en), .loop_current_setting(loop_current_setting),
    .loop_current_ma(loop_current_ma)
);

/* tb.sv */
// self-checking bench for the line supervision control block
`timescale 1ns/1ps
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       hook_cmd = 1'b0;
    logic       trip_cmd = 1'b0;
    logic       alarm_cmd = 1'b0;
    logic [7:0] rdata;
    logic       rt_pin, lc_pin, pa_pin, tip_f, ring_f, diff_f, spd, irq;
    logic [2:0] state, cur_set;
    logic [5:0] cm_volt, oh_volt, ma;
    int         num_errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    // short tick keeps debounce intervals to a few dozen cycles
    lsc_line_supervision #(.TICK_CYCLES(4)) lsc_line_supervision_i (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ring_trip_det(rt_pin), .loop_close_det(lc_pin), .power_alarm(pa_pin),
        .actual_line_state(state), .tip_force_en(tip_f), .ring_force_en(ring_f),
        .common_mode_voltage_setting(cm_volt), .diff_force_en(diff_f),
        .onhook_voltage_setting(oh_volt), .speedup_en(spd), .loop_current_setting(cur_set),
        .loop_current_ma(ma), .irq(irq));
    lsc_loop_model lsc_loop_model_i (.clk(clk), .hook_cmd(hook_cmd), .trip_cmd(trip_cmd),
        .alarm_cmd(alarm_cmd), .loop_close_det(lc_pin), .ring_trip_det(rt_pin),
        .power_alarm(pa_pin));
    always #10 clk = ~clk;
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(n, rdata, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_defaults();
        rd_chk("ctrl", 8'h43, lsc_pkg::AUTO_MAN_RST);
        rd_chk("status", 8'h44, 8'h04);
        rd_chk("lc_deb", 8'h45, {1'b0, lsc_pkg::LC_DEBOUNCE_RST});
        rd_chk("rt_deb", 8'h46, 8'h0A);
        rd_chk("cur_lim", 8'h47, 8'h00);
        check("ma", {2'h0, ma}, 8'h14);
        $display("test defaults done");
    endtask
    task automatic t_regs();
        wr_reg(8'h43, 8'hFF);
        rd_chk("ctrl_rsv", 8'h43, 8'h77);
        check("speedup_on", {7'h0, spd}, 8'h01);
        wr_reg(8'h44, 8'hFF);
        rd_chk("status_ro", 8'h44, 8'h04);
        rd_chk("unmapped", 8'h3A, 8'h00);
        wr_reg(8'h43, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr_reg(8'h47, 8'hF8 | k[7:0]);
            rd_chk("cur_lim_rb", 8'h47, k[7:0]);
            check("cur_set", {5'h0, cur_set}, k[7:0]);
            check("ma", {2'h0, ma}, 8'h14 + 8'h03 * k[7:0]);
        end
        $display("test registers done");
    endtask
    task automatic t_loop_close();
        wr_reg(8'h45, 8'h05);
        wr_reg(8'h43, 8'h02);
        wr_reg(8'h40, 8'h00);
        hook_cmd <= 1'b1;
        idle(3);
        hook_cmd <= 1'b0;
        idle(40);
        rd_chk("lc_glitch", 8'h44, 8'h04);
        check("state_glitch", {5'h0, state}, 8'h00);
        hook_cmd <= 1'b1;
        idle(4);
        rd_chk("lc_raw", 8'h44, 8'h00);
        idle(40);
        rd_chk("lc_flag", 8'h44, 8'h01);
        rd_chk("feed_shadow", 8'h40, 8'h10);
        hook_cmd <= 1'b0;
        idle(40);
        rd_chk("lc_clear", 8'h44, 8'h04);
        wr_reg(8'h43, 8'h00);
        $display("test loop closure done");
    endtask
    task automatic t_ring_trip();
        wr_reg(8'h46, 8'h00);
        wr_reg(8'h50, 8'h07);
        wr_reg(8'h40, 8'h02);
        trip_cmd <= 1'b1;
        idle(10);
        rd_chk("rt_flag", 8'h44, 8'h02);
        check("state_man", {5'h0, state}, 8'h02);
        rd_chk("rt_event", 8'h50, 8'h04);
        check("irq_masked", {7'h0, irq}, 8'h00);
        wr_reg(8'h51, 8'h04);
        idle(1);
        check("irq_on", {7'h0, irq}, 8'h01);
        wr_reg(8'h50, 8'h04);
        idle(1);
        check("irq_clr", {7'h0, irq}, 8'h00);
        trip_cmd <= 1'b0;
        idle(10);
        wr_reg(8'h43, 8'h04);
        trip_cmd <= 1'b1;
        idle(10);
        check("state_auto", {5'h0, state}, 8'h01);
        trip_cmd <= 1'b0;
        idle(10);
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h51, 8'h00);
        $display("test ring trip done");
    endtask
    task automatic t_alarm();
        wr_reg(8'h43, 8'h01);
        wr_reg(8'h40, 8'h01);
        alarm_cmd <= 1'b1;
        idle(10);
        rd_chk("feed_open", 8'h40, 8'h01);
        alarm_cmd <= 1'b0;
        wr_reg(8'h43, 8'h00);
        wr_reg(8'h40, 8'h05);
        alarm_cmd <= 1'b1;
        idle(10);
        rd_chk("feed_manual", 8'h40, 8'h55);
        alarm_cmd <= 1'b0;
        $display("test power alarm done");
    endtask
    task automatic t_force();
        wr_reg(8'h49, 8'h15);
        wr_reg(8'h48, 8'h2A);
        wr_reg(8'h43, 8'h60);
        wr_reg(8'h40, 8'h01);
        idle(1);
        check("fwd_force", {5'h0, diff_f, tip_f, ring_f}, 8'h06);
        check("cm_volt", {2'h0, cm_volt}, 8'h15);
        check("oh_volt", {2'h0, oh_volt}, 8'h2A);
        check("speedup_off", {7'h0, spd}, 8'h00);
        wr_reg(8'h40, 8'h05);
        idle(1);
        check("rev_force", {5'h0, diff_f, tip_f, ring_f}, 8'h05);
        wr_reg(8'h43, 8'h00);
        idle(1);
        check("auto_force", {5'h0, diff_f, tip_f, ring_f}, 8'h00);
        $display("test manual force done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_regs();
        t_loop_close();
        t_ring_trip();
        t_alarm();
        t_force();
        print_verdict();
    end
endmodule
